// *** logic/wcg_bit_cell.sv ***
`timescale 1ns/1ps

// ****************************************
// One bit position shared by all constants
// ****************************************
module wcg_bit_cell
	import wcg_pkg::*;
#(
	parameter wcg_sel_t THREAD = '0
) (
	input wire wcg_sel_t sel_in,
	output logic bit_out
);

	// Threaded wire reads one, bypassing wire reads zero
	always_comb begin
		bit_out = |(sel_in & THREAD); // [R3]
	end

endmodule

// *** logic/wcg_cfg.svh ***
`ifndef WCG_CFG_SVH
`define WCG_CFG_SVH

// ****************************************
// Sizes
// ****************************************
`define WCG_WORD_W 16
`define WCG_NUM_K 24

// ****************************************
// Select codes (octal)
// ****************************************
`define WCG_CODE_FIRST 7'o100
`define WCG_CODE_NINTH 7'o110
`define WCG_CODE_LAST 7'o127

// ****************************************
// Timing
// ****************************************
`define WCG_XFER_NS 2400
`define WCG_CLK_MHZ 10
`define WCG_XFER_CYC ((`WCG_XFER_NS * `WCG_CLK_MHZ) / 1000)
`define WCG_SETTLE_CYC 2

// ****************************************
// Wired constant values, one per select line
// ****************************************
`define WCG_K01 16'h0001
`define WCG_K02 16'h0002
`define WCG_K03 16'h0003
`define WCG_K04 16'h0004
`define WCG_K05 16'h0005
`define WCG_K06 16'h0006
`define WCG_K07 16'h0007
`define WCG_K08 16'h0008
`define WCG_K09 16'h0009
`define WCG_K10 16'h000a
`define WCG_K11 16'h000b
`define WCG_K12 16'h000c
`define WCG_K13 16'h000d
`define WCG_K14 16'h000e
`define WCG_K15 16'h000f
`define WCG_K16 16'h0010
`define WCG_K17 16'h0020
`define WCG_K18 16'h0040
`define WCG_K19 16'h0080
`define WCG_K20 16'h00ff
`define WCG_K21 16'h0100
`define WCG_K22 16'h0fff
`define WCG_K23 16'h7fff
`define WCG_K24 16'hffff

`endif

// *** logic/wcg_pkg.sv ***
`include "wcg_cfg.svh"

package wcg_pkg;

	typedef logic [`WCG_WORD_W-1:0] wcg_word_t;
	typedef logic [`WCG_NUM_K-1:0] wcg_sel_t;

	typedef struct packed {
		wcg_word_t data;
		logic oe_n;
		logic load;
	} wcg_bus_t;

	typedef enum logic [1:0] {
		WCG_IDLE,
		WCG_DRIVE,
		WCG_LOAD
	} wcg_state_t;

endpackage

// *** logic/wcg_top.sv ***
`timescale 1ns/1ps
`include "wcg_cfg.svh"

// Operation
// [R1] Twenty-four selectable constants, one to twenty-four
// [R2] Sixteen-bit words, one element per bit
// [R3] Threaded bit reads one, bypassed reads zero
// [R4] Octal codes 100..127 load second accumulator
// [R5] Processor decoders produce the select strobes
// [R6] Transfer completes within 2.4 microseconds
// [R7] Constant driven straight onto transfer bus
// [R8] Constant values set at build time
// [R9] Drive bus only during own selection
module wcg_top
	import wcg_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire wcg_sel_t sel_in,
	output wcg_bus_t bus_out,
	output logic busy_out,
	output logic conflict_out
);

	// ****************************************
	// Constant table
	// ****************************************
	localparam wcg_word_t KTAB [`WCG_NUM_K] = '{ // [R8]
		`WCG_K01,
		`WCG_K02,
		`WCG_K03,
		`WCG_K04,
		`WCG_K05,
		`WCG_K06,
		`WCG_K07,
		`WCG_K08,
		`WCG_K09,
		`WCG_K10,
		`WCG_K11,
		`WCG_K12,
		`WCG_K13,
		`WCG_K14,
		`WCG_K15,
		`WCG_K16,
		`WCG_K17,
		`WCG_K18,
		`WCG_K19,
		`WCG_K20,
		`WCG_K21,
		`WCG_K22,
		`WCG_K23,
		`WCG_K24
	};
	localparam logic [4:0] SETTLE_CYC = 5'(`WCG_SETTLE_CYC);

	// Wiring of one bit position across all constants
	function automatic wcg_sel_t thread_of(input int b);
		wcg_sel_t t;
		t = '0;
		for (int k = 0; k < `WCG_NUM_K; k++) begin
			t[k] = KTAB[k][b];
		end
		return t;
	endfunction

	// ****************************************
	// Select arbitration
	// ****************************************
	wcg_sel_t pick;
	logic many;

	// Lowest numbered strobe wins if several arrive together
	always_comb begin
		pick = '0;
		many = 1'b0;
		for (int k = `WCG_NUM_K - 1; k >= 0; k--) begin
			if (sel_in[k]) begin
				many = |pick;
				pick = '0;
				pick[k] = 1'b1; // [R4] [R5]
			end
		end
		if ($countones(sel_in) > 1) begin
			many = 1'b1;
		end
	end

	// ****************************************
	// Bit cells
	// ****************************************
	wcg_word_t word;

	for (genvar b = 0; b < `WCG_WORD_W; b++) begin : g_bit
		localparam wcg_sel_t THREAD_B = thread_of(b);
		wcg_bit_cell #(
			.THREAD(THREAD_B)
		) u_cell (
			.sel_in(pick),
			.bit_out(word[b])
		); // [R1] [R2]
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	wcg_state_t state_q, state_d;
	logic [4:0] cnt_q, cnt_d;
	logic take;
	logic fire;
	logic done;
	logic rest;

	// Start, load and release points of one transfer
	always_comb begin
		take = 1'b0;
		fire = 1'b0;
		done = 1'b0;
		rest = 1'b0;
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			WCG_IDLE: begin
				if (|sel_in) begin
					take = 1'b1; // [R4]
					cnt_d = SETTLE_CYC - 5'h01;
					state_d = WCG_DRIVE;
				end else begin
					rest = 1'b1; // [R9]
				end
			end
			WCG_DRIVE: begin
				if (cnt_q == 5'h00) begin
					fire = 1'b1; // [R4]
					state_d = WCG_LOAD;
				end else begin
					cnt_d = cnt_q - 5'h01;
				end
			end
			WCG_LOAD: begin
				done = 1'b1; // [R6]
				state_d = WCG_IDLE;
			end
			default: begin
				rest = 1'b1;
				cnt_d = 5'h00;
				state_d = WCG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= WCG_IDLE;
			cnt_q <= 5'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ****************************************
	// Bus drive
	// ****************************************
	wcg_bus_t bus_q, bus_d;

	// Bus is released, data zero, whenever no transfer runs
	always_comb begin
		bus_d = bus_q;
		bus_d.load = fire; // [R4]
		if (take) begin
			bus_d.data = word; // [R7]
			bus_d.oe_n = 1'b0; // [R9]
		end else if (done || rest) begin
			bus_d.data = '0;
			bus_d.oe_n = 1'b1; // [R9]
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_q.data <= '0;
			bus_q.oe_n <= 1'b1;
			bus_q.load <= 1'b0;
		end else begin
			bus_q <= bus_d;
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	logic busy_q, busy_d;
	logic conf_q, conf_d;

	// Conflict pulses for one cycle at the take
	always_comb begin
		busy_d = busy_q;
		conf_d = 1'b0;
		if (take) begin
			busy_d = 1'b1;
			conf_d = many;
		end else if (done || rest) begin
			busy_d = 1'b0; // [R6]
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_q <= 1'b0;
			conf_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
			conf_q <= conf_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus_out = bus_q;
	assign busy_out = busy_q;
	assign conflict_out = conf_q;

endmodule

// *** tb/wcg_acc_model.sv ***
`timescale 1ns/1ps
module wcg_acc_model
	import wcg_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire wcg_bus_t bus_in,
	output wcg_word_t acc_out
);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_out <= '0;
		end else if (bus_in.load && !bus_in.oe_n) begin
			acc_out <= bus_in.data;
		end
	end
endmodule

// *** tb/wcg_top_assertions.sv ***
`timescale 1ns/1ps
`include "wcg_cfg.svh"
module wcg_chk
	import wcg_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire wcg_sel_t sel_in,
	input wire wcg_bus_t bus_out,
	input wire logic busy_out,
	input wire logic conflict_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic s;
	assign s = !busy_out && |sel_in;
	property p_tk; s |=> busy_out && !bus_out.oe_n; endproperty
	a_tk: assert property (p_tk) else $error("take");
	property p_len; s |=> busy_out [*3] ##1 !busy_out; endproperty
	a_len: assert property (p_len) else $error("len");
	property p_ld; s |-> ##3 bus_out.load; endproperty
	a_ld: assert property (p_ld) else $error("load");
	property p_rel; bus_out.oe_n |-> bus_out.data == '0; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_own; !bus_out.oe_n |-> busy_out; endproperty
	a_own: assert property (p_own) else $error("stray");
	property p_k1; s && sel_in[0] |=> bus_out.data == `WCG_K01; endproperty
	a_k1: assert property (p_k1) else $error("first");
	property p_k24; s && sel_in == 24'h800000 |=> bus_out.data == `WCG_K24; endproperty
	a_k24: assert property (p_k24) else $error("last");
	property p_cf; s |=> conflict_out == ($countones($past(sel_in)) > 1); endproperty
	a_cf: assert property (p_cf) else $error("conflict");
	c_last: cover property (s && sel_in[23]);
	c_cf: cover property (conflict_out);
	c_ref: cover property (busy_out && |sel_in);
endmodule

// *** tb/wcg_top_bench.sv ***
`timescale 1ns/1ps
`include "wcg_cfg.svh"
module wcg_top_bench;
	import wcg_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	wcg_sel_t sel_in = '0;
	wcg_bus_t bus_out;
	logic busy_out, conflict_out;
	wcg_word_t acc;
	int failures = 0;
	int n_tests = 0;
	wcg_word_t kt [24] = '{`WCG_K01, `WCG_K02, `WCG_K03, `WCG_K04, `WCG_K05, `WCG_K06,
		`WCG_K07, `WCG_K08, `WCG_K09, `WCG_K10, `WCG_K11, `WCG_K12, `WCG_K13, `WCG_K14,
		`WCG_K15, `WCG_K16, `WCG_K17, `WCG_K18, `WCG_K19, `WCG_K20, `WCG_K21, `WCG_K22,
		`WCG_K23, `WCG_K24};
	wcg_top wcg_top_i (.clk_in, .rst_n_in, .sel_in, .bus_out, .busy_out, .conflict_out);
	wcg_acc_model wcg_acc_model_i (.clk_in, .rst_n_in, .bus_in(bus_out), .acc_out(acc));
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %h %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic xfer(input wcg_sel_t s, input wcg_sel_t s2, input wcg_word_t e);
		int n;
		logic multi;
		n = 0;
		multi = ($countones(s) > 1);
		@(posedge clk_in);
		sel_in <= s;
		@(posedge clk_in);
		sel_in <= s2;
		@(negedge clk_in);
		chk({1'b0, bus_out.data}, {1'b0, e});
		chk(17'({busy_out, conflict_out, bus_out.oe_n}), 17'({1'b1, multi, 1'b0}));
		repeat (2) @(posedge clk_in);
		sel_in <= '0;
		do begin
			@(negedge clk_in);
			n++;
		end while (bus_out.load !== 1'b1 && n < 21);
		if (bus_out.load !== 1'b1) begin
			failures++;
			close_out();
		end else begin
			chk(17'(n), 17'h00001);
			@(negedge clk_in);
			chk({1'b0, acc}, {1'b0, e});
			chk({bus_out.oe_n, bus_out.data}, 17'h10000);
			chk(17'({busy_out, bus_out.load}), 17'h00000);
		end
	endtask
	task automatic run_sweep();
		for (int k = 0; k < 24; k++) begin
			xfer(wcg_sel_t'(1) << k, '0, kt[k]);
		end
	endtask
	task automatic run_conflict();
		xfer(24'h800001, '0, kt[0]);
		xfer(24'h000300, '0, kt[8]);
	endtask
	task automatic run_refused();
		xfer(24'h000002, 24'h800000, kt[1]);
	endtask
	task automatic run_reset();
		@(posedge clk_in);
		sel_in <= 24'h000010;
		@(posedge clk_in);
		sel_in <= '0;
		@(negedge clk_in);
		chk({1'b0, bus_out.data}, {1'b0, kt[4]});
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		@(negedge clk_in);
		chk({bus_out.oe_n, bus_out.data}, 17'h10000);
		chk(17'({busy_out, bus_out.load}), 17'h00000);
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		xfer(24'h800000, '0, kt[23]);
	endtask
	initial forever #50 clk_in = ~clk_in;
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		run_sweep();
		run_conflict();
		run_refused();
		run_reset();
		close_out();
	end
endmodule
bind wcg_top wcg_chk wcg_chk_i (.clk_in, .rst_n_in, .sel_in, .bus_out, .busy_out, .conflict_out);
